// ### pkg/ddr_cfg_pkg.sv
// Register map, field layout, reset values and state codes of the channel configuration block
package ddr_cfg_pkg;

   // Bus geometry
   localparam int ADDR_W = 12;
   localparam int DATA_W = 32;

   // Register indices; the byte address is four times the index
   localparam logic [7:0] CLK_PAIR_DIS_IDX  = 8'h8c;
   localparam logic [7:0] CKE_DIS_IDX       = 8'h8d;
   localparam logic [7:0] CHAN_CFG_IDX      = 8'h9a;
   localparam logic [ADDR_W-1:0] CLK_PAIR_DIS_ADDR = {2'h0, CLK_PAIR_DIS_IDX, 2'h0};
   localparam logic [ADDR_W-1:0] CKE_DIS_ADDR      = {2'h0, CKE_DIS_IDX, 2'h0};
   localparam logic [ADDR_W-1:0] CHAN_CFG_ADDR     = {2'h0, CHAN_CFG_IDX, 2'h0};

   // Reset values
   localparam logic [7:0]  CLK_PAIR_DIS_RST = 8'hff;
   localparam logic [7:0]  CKE_DIS_RST      = 8'h00;
   localparam logic [15:0] CHAN_CFG_RST     = 16'h0000;

   // Channel configuration field positions
   localparam int TE_BIT    = 15;
   localparam int IDLEQ_LSB = 12;
   localparam int MIRQ_LSB  = 10;
   localparam int SPARE_BIT = 9;
   localparam int FAIL_LSB  = 7;
   localparam int SYM_BIT   = 4;

   // Calibration clock pairs as bit positions of the clock pair disable field
   localparam int CAL_BIT_A = 1;
   localparam int CAL_BIT_B = 4;
   localparam int PAIRS_PER_CHAN = 4;

   // Idle qualifier codes
   localparam logic [2:0] IQ_STAY   = 3'h0;
   localparam logic [2:0] IQ_A      = 3'h1;
   localparam logic [2:0] IQ_B      = 3'h2;
   localparam logic [2:0] IQ_DUAL   = 3'h3;
   localparam logic [2:0] IQ_SP_D   = 3'h4;
   localparam logic [2:0] IQ_SP_A   = 3'h5;
   localparam logic [2:0] IQ_SP_B   = 3'h6;
   localparam logic [2:0] IQ_MIRROR = 3'h7;

   // Mirroring qualifier codes
   localparam logic [1:0] MQ_READ01 = 2'h2;
   localparam logic [1:0] MQ_READ10 = 2'h3;

   // Configuration states; the encoding is the reported state code
   typedef enum logic [3:0] {
      ST_IDLE   = 4'h0,
      ST_A_NORM = 4'h4,
      ST_A_COPY = 4'h5,
      ST_A_DONE = 4'h7,
      ST_B_NORM = 4'h8,
      ST_B_COPY = 4'h9,
      ST_B_DONE = 4'hb,
      ST_D_NORM = 4'hc,
      ST_D_COPY = 4'hd,
      ST_D_DONE = 4'hf,
      ST_MIR01  = 4'ha,
      ST_MIR10  = 4'he
   } chan_state_t;

endpackage : ddr_cfg_pkg

// ### verilog/dimm_pin_gate.sv
// Registered gating of DIMM clock pairs and clock enable pins
`timescale 1ns/100ps
`default_nettype none
module dimm_pin_gate #(
   parameter int PAIRS = 8,
   parameter int CKES  = 8
) (
   // Clock and reset
   input  wire logic             pclk,
   input  wire logic             presetn,
   // Disable fields from software
   input  wire logic [PAIRS-1:0] clk_dis,
   input  wire logic [CKES-1:0]  cke_dis,
   // Pin drive controls
   output logic      [PAIRS-1:0] clk_pair_oe,
   output logic      [CKES-1:0]  cke_en
);
   import ddr_cfg_pkg::*;

   // One flop per pin; a disabled pair is tri-stated by dropping its enable
   genvar g;
   generate
      for (g = 0; g < PAIRS; g++) begin : g_pair
         always_ff @(posedge pclk or negedge presetn) begin
            if (!presetn) clk_pair_oe[g] <= 1'b0;
            else          clk_pair_oe[g] <= ~clk_dis[g];
         end
      end
      for (g = 0; g < CKES; g++) begin : g_cke
         always_ff @(posedge pclk or negedge presetn) begin
            if (!presetn) cke_en[g] <= 1'b1;
            else          cke_en[g] <= ~cke_dis[g];
         end
      end
   endgenerate

endmodule : dimm_pin_gate
`default_nettype wire

// ### verilog/symmetric_detect.sv
// Decision on symmetric rank interleaving
`timescale 1ns/100ps
`default_nettype none
module symmetric_detect (
   // Clock and reset
   input  wire logic pclk,
   input  wire logic presetn,
   // Conditions
   input  wire logic mirror_active,
   input  wire logic sparing_active,
   input  wire logic four_equal_ranks,
   // Decision
   output logic      symmetric_reg
);
   import ddr_cfg_pkg::*;

   // Registered so the flag never glitches while the state machine moves
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) symmetric_reg <= 1'b0;
      else          symmetric_reg <= !mirror_active && !sparing_active && four_equal_ranks;
   end

endmodule : symmetric_detect
`default_nettype wire

// ### verilog/ddr_chan_cfg.sv
// Channel configuration state machine, pin gating and APB registers of the dual channel DDR controller
`timescale 1ns/100ps
`default_nettype none
module ddr_chan_cfg (
   // Clock and reset
   input  wire logic                           pclk,
   input  wire logic                           presetn,
   // APB slave
   input  wire logic                           psel,
   input  wire logic                           penable,
   input  wire logic                           pwrite,
   input  wire logic [ddr_cfg_pkg::ADDR_W-1:0] paddr,
   input  wire logic [ddr_cfg_pkg::DATA_W-1:0] pwdata,
   output logic                                pready,
   output logic      [ddr_cfg_pkg::DATA_W-1:0] prdata,
   output logic                                pslverr,
   // DIMM clock pairs and clock enables
   output logic      [3:0]                     chan_a_clk_oe,
   output logic      [3:0]                     chan_b_clk_oe,
   output logic      [7:0]                     cke_en,
   output logic                                calib_clocks_ok,
   // Sparing migration engine
   output logic                                copy_start,
   output logic      [1:0]                     copy_source,
   input  wire logic                           copy_done,
   // Decode configuration
   input  wire logic                           four_equal_ranks,
   output logic                                sparing_enable,
   output logic                                symmetric_decode_en,
   output logic                                mirror_read10,
   output logic      [3:0]                     chan_state
);
   import ddr_cfg_pkg::*;

   // Software registers
   logic [7:0]  clk_dis_reg;
   logic [7:0]  cke_dis_reg;
   logic        te_reg;
   logic [2:0]  idleq_reg;
   logic [1:0]  mirq_reg;
   logic        spare_reg;
   logic [1:0]  fail_reg;
   logic        symmetric_reg;
   chan_state_t state_reg;
   chan_state_t state_next;
   logic        consume;
   logic        start_next;
   logic        pready_reg;

   // Bus decode
   logic access;
   logic xfer;
   logic wr_cfg;
   logic wr_te;
   logic mapped;
   logic [DATA_W-1:0] rd_mux;

   assign access = psel && penable;
   assign xfer   = access && pready_reg;
   assign mapped = (paddr == CLK_PAIR_DIS_ADDR) || (paddr == CKE_DIS_ADDR) || (paddr == CHAN_CFG_ADDR);
   assign wr_cfg = xfer && pwrite && (paddr == CHAN_CFG_ADDR);
   assign wr_te  = wr_cfg && pwdata[TE_BIT];

   // Read view; reserved bits read as zero
   always_comb begin
      rd_mux = '0;
      if (paddr == CLK_PAIR_DIS_ADDR) rd_mux[7:0] = clk_dis_reg;
      if (paddr == CKE_DIS_ADDR) rd_mux[7:0] = cke_dis_reg;
      if (paddr == CHAN_CFG_ADDR) begin
         rd_mux[15:0] = {te_reg, idleq_reg, mirq_reg, spare_reg, fail_reg, 2'h0,
                         symmetric_reg, state_reg};
      end
   end

   // One wait state: pready rises one cycle into the access phase
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) pready_reg <= 1'b0;
      else          pready_reg <= access && !pready_reg;
   end
   assign pready = pready_reg;

   // Read data and error are captured together with pready
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         prdata  <= '0;
         pslverr <= 1'b0;
      end else if (access && !pready_reg) begin
         prdata  <= pwrite ? '0 : rd_mux;
         pslverr <= !mapped;
      end else begin
         prdata  <= '0;
         pslverr <= 1'b0;
      end
   end

   // Pin disable registers
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         clk_dis_reg <= CLK_PAIR_DIS_RST;
         cke_dis_reg <= CKE_DIS_RST;
      end else if (xfer && pwrite) begin
         if (paddr == CLK_PAIR_DIS_ADDR) clk_dis_reg <= pwdata[7:0];
         if (paddr == CKE_DIS_ADDR) cke_dis_reg <= pwdata[7:0];
      end
   end

   // Qualifier, sparing and failing rank fields
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         idleq_reg <= CHAN_CFG_RST[IDLEQ_LSB +: 3];
         mirq_reg  <= CHAN_CFG_RST[MIRQ_LSB +: 2];
         spare_reg <= CHAN_CFG_RST[SPARE_BIT];
         fail_reg  <= CHAN_CFG_RST[FAIL_LSB +: 2];
      end else if (wr_cfg) begin
         idleq_reg <= pwdata[IDLEQ_LSB +: 3];
         mirq_reg  <= pwdata[MIRQ_LSB +: 2];
         spare_reg <= pwdata[SPARE_BIT];
         fail_reg  <= pwdata[FAIL_LSB +: 2];
      end
   end

   // Transition enable: a new set wins over the self-clear of the same cycle
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn)     te_reg <= CHAN_CFG_RST[TE_BIT];
      else if (wr_te)   te_reg <= 1'b1;
      else if (consume) te_reg <= 1'b0;
   end

   // Next state; every pending request is consumed in one cycle, even a refused one
   always_comb begin
      state_next = state_reg;
      consume    = te_reg;
      start_next = 1'b0;
      unique case (state_reg)
         ST_IDLE: begin
            if (te_reg) begin
               unique case (idleq_reg)
                  IQ_STAY:   state_next = ST_IDLE;
                  IQ_A:      state_next = ST_A_NORM;
                  IQ_B:      state_next = ST_B_NORM;
                  IQ_DUAL:   state_next = ST_D_NORM;
                  IQ_SP_D:   state_next = ST_D_DONE;
                  IQ_SP_A:   state_next = ST_A_DONE;
                  IQ_SP_B:   state_next = ST_B_DONE;
                  IQ_MIRROR: state_next = ST_MIR01;
               endcase
            end
         end
         ST_A_NORM, ST_B_NORM, ST_D_NORM: begin
            // Copy only on an explicit transition request with sparing on
            if (te_reg && spare_reg) begin
               start_next = 1'b1;
               state_next = chan_state_t'({state_reg[3:1], 1'b1});
            end
         end
         ST_A_COPY, ST_B_COPY, ST_D_COPY: begin
            if (copy_done) state_next = chan_state_t'({state_reg[3:2], 2'h3});
         end
         ST_MIR01, ST_MIR10: begin
            // Reserved codes leave the mirror state unchanged
            if (te_reg && mirq_reg == MQ_READ01) state_next = ST_MIR01;
            if (te_reg && mirq_reg == MQ_READ10) state_next = ST_MIR10;
         end
         ST_A_DONE, ST_B_DONE, ST_D_DONE: state_next = state_reg;
         default: state_next = ST_IDLE;
      endcase
   end

   // State register
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) state_reg <= ST_IDLE;
      else          state_reg <= state_next;
   end

   // Outputs toward the migration engine and decoder, all registered
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         copy_start          <= 1'b0;
         copy_source         <= 2'h0;
         sparing_enable      <= 1'b0;
         symmetric_decode_en <= 1'b1;
         mirror_read10       <= 1'b0;
         chan_state          <= ST_IDLE;
         calib_clocks_ok     <= 1'b0;
      end else begin
         copy_start          <= start_next;
         copy_source         <= fail_reg;
         sparing_enable      <= spare_reg;
         symmetric_decode_en <= !spare_reg;
         mirror_read10       <= (state_next == ST_MIR10);
         chan_state          <= state_next;
         calib_clocks_ok     <= !clk_dis_reg[CAL_BIT_A] && !clk_dis_reg[CAL_BIT_B];
      end
   end

   // Per-pin gating; the high nibble drives channel B
   logic [7:0] pair_oe;
   dimm_pin_gate #(
      .PAIRS (8),
      .CKES  (8)
   ) u_pin_gate (
      .pclk        (pclk),
      .presetn     (presetn),
      .clk_dis     (clk_dis_reg),
      .cke_dis     (cke_dis_reg),
      .clk_pair_oe (pair_oe),
      .cke_en      (cke_en)
   );
   assign chan_a_clk_oe = pair_oe[PAIRS_PER_CHAN-1:0];
   assign chan_b_clk_oe = pair_oe[2*PAIRS_PER_CHAN-1:PAIRS_PER_CHAN];

   // Interleave decision
   logic mirror_active;
   logic sparing_active;
   assign mirror_active  = (state_reg == ST_MIR01) || (state_reg == ST_MIR10);
   assign sparing_active = spare_reg || state_reg[0];
   symmetric_detect u_sym (
      .pclk             (pclk),
      .presetn          (presetn),
      .mirror_active    (mirror_active),
      .sparing_active   (sparing_active),
      .four_equal_ranks (four_equal_ranks),
      .symmetric_reg    (symmetric_reg)
   );

   // Checks on the state machine and pins
   a_clk_pair_gate: assert property (@(posedge pclk) disable iff (!presetn)
      chan_a_clk_oe == ~$past(clk_dis_reg[3:0]) && chan_b_clk_oe == ~$past(clk_dis_reg[7:4]))
      else $error("clock pair enable does not follow disable field");
   a_cke_gate: assert property (@(posedge pclk) disable iff (!presetn)
      cke_en == ~$past(cke_dis_reg))
      else $error("clock enable pins do not follow disable field");
   a_calib_pairs: assert property (@(posedge pclk) disable iff (!presetn)
      calib_clocks_ok == (chan_a_clk_oe[1] && chan_b_clk_oe[0]))
      else $error("calibration clock status wrong");
   a_te_self_clear: assert property (@(posedge pclk) disable iff (!presetn)
      te_reg && !wr_te |=> !te_reg)
      else $error("transition enable not cleared");
   a_te_zero_write: assert property (@(posedge pclk) disable iff (!presetn)
      !te_reg && wr_cfg && !pwdata[TE_BIT] |=> !te_reg)
      else $error("writing zero set transition enable");
   a_idle_single: assert property (@(posedge pclk) disable iff (!presetn)
      state_reg == ST_IDLE && te_reg && idleq_reg == IQ_B |=> chan_state == 4'h8 && state_reg == ST_B_NORM)
      else $error("idle did not enter single channel B");
   a_idle_stay: assert property (@(posedge pclk) disable iff (!presetn)
      state_reg == ST_IDLE && !te_reg |=> state_reg == ST_IDLE)
      else $error("idle left without transition enable");
   a_idle_spared: assert property (@(posedge pclk) disable iff (!presetn)
      state_reg == ST_IDLE && te_reg && idleq_reg == IQ_SP_D |=> state_reg == ST_D_DONE)
      else $error("direct spared entry failed");
   a_idle_mirror: assert property (@(posedge pclk) disable iff (!presetn)
      state_reg == ST_IDLE && te_reg && idleq_reg == IQ_MIRROR |=> chan_state == 4'ha && !mirror_read10)
      else $error("mirror entry failed");
   a_mirror_step: assert property (@(posedge pclk) disable iff (!presetn)
      mirror_active && te_reg && mirq_reg == MQ_READ10 |=> state_reg == ST_MIR10 && mirror_read10)
      else $error("mirror read10 step failed");
   a_no_copy_idle_te: assert property (@(posedge pclk) disable iff (!presetn)
      state_reg == ST_D_NORM && !te_reg |=> state_reg == ST_D_NORM && !copy_start)
      else $error("copy began without transition enable");
   a_copy_starts: assert property (@(posedge pclk) disable iff (!presetn)
      state_reg == ST_A_NORM && te_reg && spare_reg |=> copy_start && state_reg == ST_A_COPY)
      else $error("sparing copy did not start");
   a_copy_done: assert property (@(posedge pclk) disable iff (!presetn)
      state_reg == ST_D_COPY && copy_done |=> state_reg == ST_D_DONE && chan_state == 4'hf)
      else $error("copy completion not taken");
   a_spare_decode: assert property (@(posedge pclk) disable iff (!presetn)
      sparing_enable == $past(spare_reg) && symmetric_decode_en == !sparing_enable)
      else $error("sparing and symmetric decode disagree");
   a_sym_flag: assert property (@(posedge pclk) disable iff (!presetn)
      $past(mirror_active) || $past(spare_reg) |-> !symmetric_reg)
      else $error("symmetric flag set while mirrored or spared");
   a_apb_wait: assert property (@(posedge pclk) disable iff (!presetn)
      access && !pready_reg |=> pready_reg ##1 !pready_reg)
      else $error("bus answer not one cycle");

   c_dual_copy: cover property (@(posedge pclk) disable iff (!presetn)
      state_reg == ST_D_COPY ##[1:50] state_reg == ST_D_DONE);
   c_mirror_r10: cover property (@(posedge pclk) disable iff (!presetn)
      state_reg == ST_MIR01 ##[1:50] state_reg == ST_MIR10);
   c_te_race: cover property (@(posedge pclk) disable iff (!presetn) consume && wr_te);
   c_unmapped: cover property (@(posedge pclk) disable iff (!presetn) pslverr);

endmodule : ddr_chan_cfg
`default_nettype wire

// ### dv/copy_engine_model.sv
// Behavioural sparing migration engine that answers the copy start pulse
`timescale 1ns/100ps
`default_nettype none
module copy_engine_model (
   // Clock and reset
   input  wire logic       pclk,
   input  wire logic       presetn,
   // Copy handshake
   input  wire logic       copy_start,
   input  wire logic [1:0] copy_source,
   input  wire logic [7:0] copy_lat,
   output logic            copy_done,
   // Observation for the bench
   output logic      [1:0] seen_src,
   output var int          starts
);
   logic       busy_reg;
   logic [7:0] left_reg;

   // Counts out the copy, then pulses done once; done stays low otherwise so no stale level lingers
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         busy_reg  <= 1'b0;
         left_reg  <= 8'h00;
         copy_done <= 1'b0;
         seen_src  <= 2'h0;
         starts    <= 0;
      end else begin
         copy_done <= 1'b0;
         if (copy_start) begin
            busy_reg <= 1'b1;
            left_reg <= copy_lat;
            seen_src <= copy_source;
            starts   <= starts + 1;
         end else if (busy_reg && left_reg == 8'h00) begin
            busy_reg  <= 1'b0;
            copy_done <= 1'b1;
         end else if (busy_reg) begin
            left_reg <= left_reg - 8'h01;
         end
      end
   end
endmodule : copy_engine_model
`default_nettype wire

// ### dv/ddr_channel_config_and_pin_gating_tb.sv
// Self-checking bench for the channel configuration and pin gating block
`timescale 1ns/100ps
`default_nettype none
module ddr_channel_config_and_pin_gating_tb;
   import ddr_cfg_pkg::*;

   typedef struct packed {
      logic [7:0] cd;
      logic [7:0] kd;
      logic [7:0] oe;
      logic       ok;
      logic [7:0] ke;
   } gate_row_t;

   // Disable values beside the pin enables they should give
   const gate_row_t rows[5] = '{
      '{8'hff, 8'h00, 8'h00, 1'b0, 8'hff},
      '{8'h00, 8'hff, 8'hff, 1'b1, 8'h00},
      '{8'hfd, 8'h01, 8'h02, 1'b0, 8'hfe},
      '{8'hef, 8'h80, 8'h10, 1'b0, 8'h7f},
      '{8'hed, 8'h5a, 8'h12, 1'b1, 8'ha5}};
   const logic [3:0] st_exp[8] = '{4'h0, 4'h4, 4'h8, 4'hc, 4'hf, 4'h7, 4'hb, 4'ha};
   const logic [2:0] norm_q[2] = '{3'h3, 3'h1};
   const logic [3:0] norm_st[2] = '{4'hc, 4'h4};

   logic              pclk = 1'b0;
   logic              presetn = 1'b0;
   logic              psel = 1'b0;
   logic              penable = 1'b0;
   logic              pwrite = 1'b0;
   logic [ADDR_W-1:0] paddr = '0;
   logic [DATA_W-1:0] pwdata = '0;
   logic              four_equal_ranks = 1'b0;
   logic [7:0]        copy_lat = 8'h09;
   logic              pready, pslverr, calib_clocks_ok, copy_start, copy_done;
   logic              sparing_enable, symmetric_decode_en, mirror_read10;
   logic [DATA_W-1:0] prdata, rd;
   logic [3:0]        chan_a_clk_oe, chan_b_clk_oe, chan_state;
   logic [7:0]        cke_en;
   logic [1:0]        copy_source, seen_src;
   logic              err;
   int                starts;
   int                fail_count = 0;
   int                cmp_count = 0;

   // 10 MHz clock
   always #50 pclk = ~pclk;

   ddr_chan_cfg dut_u (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
      .paddr(paddr), .pwdata(pwdata), .pready(pready), .prdata(prdata), .pslverr(pslverr),
      .chan_a_clk_oe(chan_a_clk_oe), .chan_b_clk_oe(chan_b_clk_oe), .cke_en(cke_en),
      .calib_clocks_ok(calib_clocks_ok), .copy_start(copy_start), .copy_source(copy_source),
      .copy_done(copy_done), .four_equal_ranks(four_equal_ranks), .sparing_enable(sparing_enable),
      .symmetric_decode_en(symmetric_decode_en), .mirror_read10(mirror_read10), .chan_state(chan_state));

   copy_engine_model engine_u (.pclk(pclk), .presetn(presetn), .copy_start(copy_start),
      .copy_source(copy_source), .copy_lat(copy_lat), .copy_done(copy_done), .seen_src(seen_src),
      .starts(starts));

   task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
      cmp_count++;
      if (got !== exp) begin
         fail_count++;
         $display("mismatch %s expected %h seen %h", what, exp, got);
      end
   endtask : chk

   // One APB transfer; request held until pready is sampled high, bounded wait
   task automatic apb(input logic wr, input logic [ADDR_W-1:0] a, input logic [31:0] d);
      int n;
      n = 0;
      @(posedge pclk);
      psel    <= 1'b1;
      penable <= 1'b0;
      pwrite  <= wr;
      paddr   <= a;
      pwdata  <= d;
      @(posedge pclk);
      penable <= 1'b1;
      do begin
         @(posedge pclk);
         n++;
      end while (pready !== 1'b1 && n < 20);
      rd = prdata;
      err = pslverr;
      psel    <= 1'b0;
      penable <= 1'b0;
      if (n >= 20) chk("pready", 32'h1, 32'h0);
   endtask : apb

   task automatic wait_cyc(input int n);
      repeat (n) @(posedge pclk);
      #1;
   endtask : wait_cyc

   task automatic do_reset;
      presetn <= 1'b0;
      repeat (10) @(posedge pclk);
      presetn <= 1'b1;
   endtask : do_reset

   task automatic wrap_up;
      $display("comparisons %0d mismatches %0d", cmp_count, fail_count);
      if (fail_count == 0 && cmp_count > 0)
         $display("Finished cleanly");
      else
         $display("Finished with errors");
      $finish;
   endtask : wrap_up

   // Watchdog: the tests need about 400 cycles, so 40000 means a hang
   initial begin
      #4000000;
      fail_count++;
      wrap_up();
   end

   initial begin
      do_reset();
      wait_cyc(2);
      // Reset values at pins and registers
      chk("clk oe rst", 32'h0, 32'({chan_b_clk_oe, chan_a_clk_oe}));
      chk("cke_en rst", 32'hff, 32'(cke_en));
      apb(1'b0, CLK_PAIR_DIS_ADDR, 32'h0);
      chk("clk_dis rst", 32'hff, rd);
      apb(1'b0, CKE_DIS_ADDR, 32'h0);
      chk("cke_dis rst", 32'h0, rd);
      apb(1'b0, CHAN_CFG_ADDR, 32'h0);
      chk("cfg rst", 32'h0, rd);
      // Table of gating values; the last row keeps both calibration pairs on
      foreach (rows[i]) begin
         apb(1'b1, CLK_PAIR_DIS_ADDR, 32'(rows[i].cd));
         apb(1'b1, CKE_DIS_ADDR, 32'(rows[i].kd));
         wait_cyc(2);
         chk("clk oe", 32'(rows[i].oe), 32'({chan_b_clk_oe, chan_a_clk_oe}));
         chk("calib ok", 32'(rows[i].ok), 32'(calib_clocks_ok));
         chk("cke_en", 32'(rows[i].ke), 32'(cke_en));
         apb(1'b0, CLK_PAIR_DIS_ADDR, 32'h0);
         chk("clk_dis rd", 32'(rows[i].cd), rd);
      end
      // Unmapped address is refused
      apb(1'b0, 12'h000, 32'h0);
      chk("unmapped err", 32'h1, 32'(err));
      chk("unmapped rd", 32'h0, rd);
      // Every idle qualifier from a fresh reset
      for (int c = 0; c < 8; c++) begin
         do_reset();
         wait_cyc(1);
         apb(1'b1, CHAN_CFG_ADDR, 32'h8000 | 32'(c << 12));
         wait_cyc(3);
         chk("idle step", 32'(st_exp[c]), 32'(chan_state));
         apb(1'b0, CHAN_CFG_ADDR, 32'h0);
         chk("cfg te clr", 32'(c << 12) | 32'(st_exp[c]), rd);
      end
      // Mirror steps; a reserved qualifier leaves the state alone
      apb(1'b1, CHAN_CFG_ADDR, 32'hfc00);
      wait_cyc(3);
      chk("read10", 32'h1e, {27'h0, mirror_read10, chan_state});
      apb(1'b1, CHAN_CFG_ADDR, 32'hf000);
      wait_cyc(3);
      apb(1'b0, CHAN_CFG_ADDR, 32'h0);
      chk("mq reserved", 32'h700e, rd);
      apb(1'b1, CHAN_CFG_ADDR, 32'hf800);
      wait_cyc(3);
      chk("read01", 32'h0a, {27'h0, mirror_read10, chan_state});
      // Sparing copy in dual and single A, slow then prompt engine
      four_equal_ranks <= 1'b1;
      for (int k = 0; k < 2; k++) begin
         do_reset();
         copy_lat <= (k == 0) ? 8'h09 : 8'h01;
         wait_cyc(1);
         apb(1'b1, CHAN_CFG_ADDR, 32'h8000 | 32'(norm_q[k]) << 12);
         wait_cyc(3);
         apb(1'b0, CHAN_CFG_ADDR, 32'h0);
         chk("sym on", 32'(norm_q[k]) << 12 | 32'h10 | 32'(norm_st[k]), rd);
         apb(1'b1, CHAN_CFG_ADDR, 32'(norm_q[k]) << 12 | 32'h300);
         wait_cyc(4);
         chk("no te copy", 32'(norm_st[k]), 32'(chan_state));
         chk("starts idle", 32'h0, 32'(starts));
         chk("spare pins", 32'h6, {29'h0, sparing_enable, copy_source});
         chk("sym decode", 32'h0, 32'(symmetric_decode_en));
         apb(1'b1, CHAN_CFG_ADDR, 32'h8000 | 32'(norm_q[k]) << 12 | 32'h300);
         wait_cyc(2);
         chk("copying", 32'(norm_st[k] + 4'h1), 32'(chan_state));
         chk("one start", 32'h6, {28'(starts), 2'h0} | 32'(seen_src));
         wait_cyc(15);
         apb(1'b0, CHAN_CFG_ADDR, 32'h0);
         chk("copy done", 32'(norm_q[k]) << 12 | 32'h300 | 32'(norm_st[k] + 4'h3), rd);
      end
      wrap_up();
   end
endmodule : ddr_channel_config_and_pin_gating_tb
`default_nettype wire
